// >>> rtl/ssp_map.vh
/*
  Register map, field positions, reset values and timing counts of the synchronous serial port.
  Assumes it is included by bare name from the files under rtl/.
*/
`ifndef SSP_MAP_VH
`define SSP_MAP_VH

`define ADDR_CONFIG_CONTROL    16'h7040
`define ADDR_OPERATION_CONTROL 16'h7041
`define ADDR_PORT_STATUS       16'h7042
`define ADDR_BIT_RATE_DIVISOR  16'h7044
`define ADDR_RX_EMULATION      16'h7046
`define ADDR_RX_BUFFER         16'h7047
`define ADDR_TX_BUFFER         16'h7048
`define ADDR_SHIFT_DATA        16'h7049
`define ADDR_FIFO_TX_CONTROL   16'h704A
`define ADDR_FIFO_RX_CONTROL   16'h704B
`define ADDR_FIFO_CONTROL      16'h704C
`define ADDR_PRIORITY_CONTROL  16'h704F

`define CFG_LEN_HI       3
`define CFG_POLARITY     6
`define CFG_RUN          7
`define OPC_RX_INT_EN    0
`define OPC_TX_EN        1
`define OPC_MASTER       2
`define OPC_PHASE        3
`define OPC_OVR_INT_EN   4
`define OPC_TX_INT_EN    5
`define STS_TX_FULL      5
`define STS_RX_DONE      6
`define STS_OVERRUN      7

`define RST_CONFIG       8'h00
`define RST_OPERATION    8'h00
`define RST_DIVISOR      7'h00
`define RST_DELAY        8'h00
`define RST_PRIORITY     8'h00

`define DIV_MIN_CODE     7'h03
`define DIV_SLOW_PERIOD  8'h04

`endif

// >>> rtl/word_fifo.v
/*
  Parameterised first-in first-out word store with valid/ready on both sides.
  The head word comes out of a register; assumes one clock and an asynchronous active-high reset.
*/
`default_nettype none

module word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data_ff,
  output reg  [AW:0]      level_ff
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_ff;
  reg  [AW-1:0]    rd_ptr_ff;
  wire             push;
  wire             pop;
  wire [AW-1:0]    nxt_rd_ptr;

  assign in_ready   = (level_ff != DEPTH[AW:0]);
  assign out_valid  = (level_ff != {(AW+1){1'b0}});
  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;

  always @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // The head register is refreshed every cycle; a write landing on the new head bypasses the array.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_ff   <= {AW{1'b0}};
      rd_ptr_ff   <= {AW{1'b0}};
      level_ff    <= {(AW+1){1'b0}};
      out_data_ff <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      rd_ptr_ff <= nxt_rd_ptr;
      if (push & ~pop)
      begin
        level_ff <= level_ff + 1'b1;
      end
      else if (pop & ~push)
      begin
        level_ff <= level_ff - 1'b1;
      end
      if (push && wr_ptr_ff == nxt_rd_ptr)
      begin
        out_data_ff <= in_data;
      end
      else
      begin
        out_data_ff <= mem[nxt_rd_ptr];
      end
    end
  end

endmodule

`default_nettype wire

// >>> rtl/rate_divider.v
/*
  Serial clock rate divider producing one-cycle leading and trailing edge enables.
  Assumes the system clock stands in for the low-speed peripheral clock.
*/
`default_nettype none
`include "ssp_map.vh"

module rate_divider (
  input  wire       clk,
  input  wire       rst,
  input  wire       run,
  input  wire [6:0] divisor,
  output reg        lead_tick_ff,
  output reg        trail_tick_ff
);

  reg  [7:0] cnt_ff;
  wire [7:0] period;
  wire [7:0] half;

  // Codes below the minimum all fall back to the divide-by-four rate.
  assign period = (divisor < `DIV_MIN_CODE) ? `DIV_SLOW_PERIOD : {1'b0, divisor} + 8'h01;
  assign half   = {1'b0, period[7:1]};

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff        <= 8'h00;
      lead_tick_ff  <= 1'b0;
      trail_tick_ff <= 1'b0;
    end
    else if (!run)
    begin
      cnt_ff        <= 8'h00;
      lead_tick_ff  <= 1'b0;
      trail_tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff        <= (cnt_ff == period - 8'h01) ? 8'h00 : cnt_ff + 8'h01;
      lead_tick_ff  <= (cnt_ff == half - 8'h01);
      trail_tick_ff <= (cnt_ff == period - 8'h01);
    end
  end

endmodule

`default_nettype wire

// >>> rtl/sync_serial_port.v
/*
  Synchronous serial port: register file, master/slave shifter, pin drivers and a transmit FIFO.
  Assumes a 50 MHz clk standing for the peripheral clock, and 16-bit register accesses only.
*/
// Contract
// - Word length is programmable from 1 to 16 bits, same count in and out.
// - Master bit rate is clock/(divisor+1) for 3..127, clock/4 for codes 0..2.
// - Software selects master role, driving the serial clock, or slave, accepting it.
// - Idle-low scheme without delay launches on falling edge, samples on rising.
// - Idle-low scheme with delay launches half cycle early, samples on falling edge.
// - Idle-high scheme without delay launches on rising edge, samples on falling.
// - Idle-high scheme with delay launches half cycle early, samples on rising edge.
// - Receive and transmit run together; software may disable transmit only.
// - Slave-out line is driven as slave and sampled as master.
// - Slave-in line is driven as master and sampled as slave.
// - Transmit-enable line is asserted by master; slave takes part only while active.
// - Completion is visible as interrupt requests and as pollable status flags.
// - Register value sits in bits 7-0; upper byte reads zero, writes ignored.
`default_nettype none
`include "ssp_map.vh"

module sync_serial_port #(
  parameter DATA_W     = 16,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [15:0] addr,
  input  wire        wr_en,
  input  wire        rd_en,
  input  wire [15:0] wr_data,
  output reg  [15:0] rd_data_ff,
  output reg         rx_irq_ff,
  output reg         tx_irq_ff,
  input  wire        somi_i,
  output reg         somi_o_ff,
  output reg         somi_oe_ff,
  input  wire        simo_i,
  output reg         simo_o_ff,
  output reg         simo_oe_ff,
  input  wire        sclk_i,
  output reg         sclk_o_ff,
  output reg         sclk_oe_ff,
  input  wire        ste_n_i,
  output reg         ste_n_o_ff,
  output reg         ste_oe_ff
);

  localparam ST_IDLE  = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam ST_GAP   = 2'b10;

  reg  [7:0]        cfg_ff;
  reg  [7:0]        opc_ff;
  reg  [6:0]        div_ff;
  reg  [7:0]        delay_ff;
  reg  [7:0]        prio_ff;
  reg               rx_done_ff;
  reg               overrun_ff;
  reg  [15:0]       rx_buf_ff;
  reg  [15:0]       sh_ff;
  reg               rbit_ff;
  reg  [5:0]        edge_cnt_ff;
  reg  [1:0]        state_ff;
  reg  [7:0]        gap_ff;
  reg               loaded_ff;
  reg               sclk_s1_ff;
  reg               sclk_s2_ff;
  reg               sclk_s3_ff;
  reg               simo_s1_ff;
  reg               simo_s2_ff;
  reg               somi_s1_ff;
  reg               somi_s2_ff;
  reg               ste_s1_ff;
  reg               ste_s2_ff;
  reg  [7:0]        nxt_rd_byte;

  wire              running;
  wire              master;
  wire              phase;
  wire              pol;
  wire              tx_en;
  wire [4:0]        len;
  wire [5:0]        last_edge;
  wire              slave_act;
  wire              tick_lead;
  wire              tick_trail;
  wire              s_rise;
  wire              s_fall;
  wire              lead_ev;
  wire              trail_ev;
  wire              in_bit;
  wire              fifo_in_valid;
  wire              fifo_in_ready;
  wire              fifo_out_valid;
  wire [DATA_W-1:0] fifo_out_data;
  wire [FIFO_AW:0]  fifo_level;
  wire              pop;
  wire              word_end;
  wire              wr_hit_tx;
  wire              rd_rx_buf;

  // Left-justify a word so that bit (length-1) leaves first from the top of the shifter.
  function [15:0] align;
    input [15:0] word;
    input [3:0]  lenm1;
    begin
      align = word << (4'hF - lenm1);
    end
  endfunction

  function hit;
    input [15:0] a;
    input [15:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  assign running   = cfg_ff[`CFG_RUN];
  assign pol       = cfg_ff[`CFG_POLARITY];
  assign len       = {1'b0, cfg_ff[`CFG_LEN_HI:0]} + 5'h01;
  assign last_edge = {len, 1'b0} - 6'h01;
  assign master    = opc_ff[`OPC_MASTER];
  assign phase     = opc_ff[`OPC_PHASE];
  assign tx_en     = opc_ff[`OPC_TX_EN];
  assign slave_act = running & ~master & ~ste_s2_ff;

  assign s_rise   = sclk_s2_ff & ~sclk_s3_ff;
  assign s_fall   = ~sclk_s2_ff & sclk_s3_ff;
  // The leading edge leaves the idle level: rising when idle low, falling when idle high.
  assign lead_ev  = master ? tick_lead : (slave_act & (pol ? s_fall : s_rise));
  assign trail_ev = master ? tick_trail : (slave_act & (pol ? s_rise : s_fall));
  assign in_bit   = master ? somi_s2_ff : simo_s2_ff;
  assign word_end = trail_ev & (edge_cnt_ff == last_edge) & (state_ff == ST_SHIFT | ~master);

  assign wr_hit_tx     = wr_en & (hit(addr, `ADDR_TX_BUFFER) | hit(addr, `ADDR_SHIFT_DATA));
  assign fifo_in_valid = wr_hit_tx;
  assign rd_rx_buf     = rd_en & hit(addr, `ADDR_RX_BUFFER);
  assign pop = running & fifo_out_valid & (master ? (state_ff == ST_IDLE) : (~loaded_ff & edge_cnt_ff == 6'h00));

  // A full FIFO refuses writes; software sees it in the status word and must wait.
  word_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_tx_fifo (
    .clk         (clk),
    .rst         (rst),
    .in_valid    (fifo_in_valid),
    .in_ready    (fifo_in_ready),
    .in_data     ({{(DATA_W-8){1'b0}}, wr_data[7:0]}),
    .out_valid   (fifo_out_valid),
    .out_ready   (pop),
    .out_data_ff (fifo_out_data),
    .level_ff    (fifo_level)
  );

  rate_divider u_div (
    .clk           (clk),
    .rst           (rst),
    .run           (master & (state_ff == ST_SHIFT)),
    .divisor       (div_ff),
    .lead_tick_ff  (tick_lead),
    .trail_tick_ff (tick_trail)
  );

  // Pin inputs are resynchronised; at the fastest divisor this costs two cycles of sample margin.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      simo_s1_ff <= 1'b0;
      simo_s2_ff <= 1'b0;
      somi_s1_ff <= 1'b0;
      somi_s2_ff <= 1'b0;
      ste_s1_ff  <= 1'b1;
      ste_s2_ff  <= 1'b1;
    end
    else
    begin
      sclk_s1_ff <= sclk_i;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      simo_s1_ff <= simo_i;
      simo_s2_ff <= simo_s1_ff;
      somi_s1_ff <= somi_i;
      somi_s2_ff <= somi_s1_ff;
      ste_s1_ff  <= ste_n_i;
      ste_s2_ff  <= ste_s1_ff;
    end
  end

  // Register writes keep only the low byte.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_ff   <= `RST_CONFIG;
      opc_ff   <= `RST_OPERATION;
      div_ff   <= `RST_DIVISOR;
      delay_ff <= `RST_DELAY;
      prio_ff  <= `RST_PRIORITY;
    end
    else if (wr_en)
    begin
      if (hit(addr, `ADDR_CONFIG_CONTROL))
        cfg_ff <= wr_data[7:0];
      if (hit(addr, `ADDR_OPERATION_CONTROL))
        opc_ff <= wr_data[7:0];
      if (hit(addr, `ADDR_BIT_RATE_DIVISOR))
        div_ff <= wr_data[6:0];
      if (hit(addr, `ADDR_FIFO_CONTROL))
        delay_ff <= wr_data[7:0];
      if (hit(addr, `ADDR_PRIORITY_CONTROL))
        prio_ff <= wr_data[7:0];
    end
  end

  always @*
  begin
    nxt_rd_byte = 8'h00;
    case (addr)
      `ADDR_CONFIG_CONTROL:    nxt_rd_byte = cfg_ff;
      `ADDR_OPERATION_CONTROL: nxt_rd_byte = opc_ff;
      `ADDR_PORT_STATUS:       nxt_rd_byte = {overrun_ff, rx_done_ff, ~fifo_in_ready, 5'h00};
      `ADDR_BIT_RATE_DIVISOR:  nxt_rd_byte = {1'b0, div_ff};
      `ADDR_RX_EMULATION:      nxt_rd_byte = rx_buf_ff[7:0];
      `ADDR_RX_BUFFER:         nxt_rd_byte = rx_buf_ff[7:0];
      `ADDR_TX_BUFFER:         nxt_rd_byte = fifo_out_data[7:0];
      `ADDR_SHIFT_DATA:        nxt_rd_byte = sh_ff[7:0];
      `ADDR_FIFO_TX_CONTROL:   nxt_rd_byte = {3'h0, fifo_level};
      `ADDR_FIFO_RX_CONTROL:   nxt_rd_byte = {7'h00, rx_done_ff};
      `ADDR_FIFO_CONTROL:      nxt_rd_byte = delay_ff;
      `ADDR_PRIORITY_CONTROL:  nxt_rd_byte = prio_ff;
      default:                 nxt_rd_byte = 8'h00;
    endcase
  end

  // Reading the receive buffer clears its flag, but a word finishing in the same cycle sets it again.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_ff <= 16'h0000;
      rx_done_ff <= 1'b0;
      overrun_ff <= 1'b0;
      rx_buf_ff  <= 16'h0000;
      rx_irq_ff  <= 1'b0;
      tx_irq_ff  <= 1'b0;
    end
    else
    begin
      if (rd_en)
        rd_data_ff <= {8'h00, nxt_rd_byte};
      if (word_end)
      begin
        rx_buf_ff  <= (phase ? {sh_ff[14:0], in_bit} : {sh_ff[14:0], rbit_ff}) & ~(16'hFFFF << len);
        rx_done_ff <= 1'b1;
        if (rx_done_ff & ~rd_rx_buf)
          overrun_ff <= 1'b1;
      end
      else if (rd_rx_buf)
      begin
        rx_done_ff <= 1'b0;
      end
      if (wr_en && hit(addr, `ADDR_PORT_STATUS) && wr_data[`STS_OVERRUN] && !(word_end && rx_done_ff))
        overrun_ff <= 1'b0;
      rx_irq_ff <= (rx_done_ff & opc_ff[`OPC_RX_INT_EN]) | (overrun_ff & opc_ff[`OPC_OVR_INT_EN]);
      tx_irq_ff <= ~fifo_out_valid & (state_ff == ST_IDLE) & opc_ff[`OPC_TX_INT_EN];
    end
  end

  // Shifter shared by both roles; the edge source, the input pin, the load condition and the slave's deselect clear differ.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff    <= ST_IDLE;
      sh_ff       <= 16'h0000;
      rbit_ff     <= 1'b0;
      edge_cnt_ff <= 6'h00;
      gap_ff      <= 8'h00;
      loaded_ff   <= 1'b0;
    end
    else if (!running)
    begin
      state_ff    <= ST_IDLE;
      edge_cnt_ff <= 6'h00;
      loaded_ff   <= 1'b0;
    end
    else
    begin
      if (pop)
      begin
        sh_ff     <= align(fifo_out_data, cfg_ff[`CFG_LEN_HI:0]);
        loaded_ff <= 1'b1;
      end
      if (!master && ste_s2_ff)
        edge_cnt_ff <= 6'h00;
      else if (lead_ev)
      begin
        rbit_ff     <= in_bit;
        edge_cnt_ff <= edge_cnt_ff + 6'h01;
      end
      else if (trail_ev)
      begin
        sh_ff       <= phase ? {sh_ff[14:0], in_bit} : {sh_ff[14:0], rbit_ff};
        edge_cnt_ff <= (edge_cnt_ff == last_edge) ? 6'h00 : edge_cnt_ff + 6'h01;
        if (edge_cnt_ff == last_edge)
          loaded_ff <= 1'b0;
      end
      case (state_ff)
        ST_IDLE:
        begin
          if (master && pop)
            state_ff <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          if (word_end)
          begin
            state_ff <= ST_GAP;
            gap_ff   <= delay_ff;
          end
        end
        ST_GAP:
        begin
          // The programmed gap delays the next word, giving slow slaves time between words.
          if (gap_ff == 8'h00)
            state_ff <= ST_IDLE;
          else
            gap_ff <= gap_ff - 8'h01;
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin drivers: master owns clock, enable and slave-in; slave owns slave-out only while selected.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_o_ff  <= 1'b0;
      sclk_oe_ff <= 1'b0;
      ste_n_o_ff <= 1'b1;
      ste_oe_ff  <= 1'b0;
      simo_o_ff  <= 1'b0;
      simo_oe_ff <= 1'b0;
      somi_o_ff  <= 1'b0;
      somi_oe_ff <= 1'b0;
    end
    else
    begin
      sclk_oe_ff <= running & master;
      ste_oe_ff  <= running & master;
      ste_n_o_ff <= ~(master & (state_ff == ST_SHIFT));
      if (!master || state_ff != ST_SHIFT)
        sclk_o_ff <= pol;
      else if (tick_lead || tick_trail)
        sclk_o_ff <= ~sclk_o_ff;
      simo_oe_ff <= running & master & tx_en;
      somi_oe_ff <= slave_act & tx_en;
      if (pop)
        simo_o_ff <= fifo_out_data[cfg_ff[`CFG_LEN_HI:0]];
      else if (phase && lead_ev)
        simo_o_ff <= sh_ff[15];
      else if (!phase && trail_ev)
        simo_o_ff <= sh_ff[14];
      somi_o_ff <= simo_o_ff;
    end
  end

endmodule

`default_nettype wire

// >>> test/ssp_assertions.sv
/*
  Pin and register-bus properties of the serial port, bound to its top module.
  Assumes the register map header is on the include path.
*/
`default_nettype none
`include "ssp_map.vh"
module ssp_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] addr,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] rd_data_ff,
  input wire logic        somi_oe_ff,
  input wire logic        simo_oe_ff,
  input wire logic        sclk_o_ff,
  input wire logic        sclk_oe_ff,
  input wire logic        ste_n_i,
  input wire logic        ste_n_o_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_upper_zero;
    rd_data_ff[15:8] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read byte set");
  property p_unmapped;
    rd_en && addr == 16'h7043 |=> rd_data_ff == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_byte_lane;
    wr_en && addr == `ADDR_PRIORITY_CONTROL ##2 rd_en && addr == `ADDR_PRIORITY_CONTROL
      |=> rd_data_ff == ($past(wr_data, 3) & 16'h00FF);
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("written byte not read back");
  property p_one_role;
    !(sclk_oe_ff && somi_oe_ff);
  endproperty
  a_one_role: assert property (p_one_role) else $error("clock and slave output both driven");
  property p_master_out;
    simo_oe_ff |-> sclk_oe_ff;
  endproperty
  a_master_out: assert property (p_master_out) else $error("master out driven outside master role");
  // Five samples cover the two-stage synchroniser plus the output register.
  property p_idle_slave;
    ste_n_i [*5] |-> !somi_oe_ff;
  endproperty
  a_idle_slave: assert property (p_idle_slave) else $error("deselected slave drives output");
  property p_clock_in_frame;
    $past(sclk_oe_ff) && sclk_oe_ff && $changed(sclk_o_ff) |-> !$past(ste_n_o_ff);
  endproperty
  a_clock_in_frame: assert property (p_clock_in_frame) else $error("clock edge without select");
  property p_half_period;
    $past(sclk_oe_ff) && sclk_oe_ff && $changed(sclk_o_ff) |=> $stable(sclk_o_ff);
  endproperty
  a_half_period: assert property (p_half_period) else $error("serial clock faster than clk/4");
  c_clock: cover property (sclk_oe_ff && $rose(sclk_o_ff));
  c_slave: cover property ($rose(somi_oe_ff));
  c_frame: cover property ($fell(ste_n_o_ff) ##[1:40] $rose(ste_n_o_ff));
endmodule
bind sync_serial_port ssp_assertions ssp_assertions_inst (
  .clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data),
  .rd_data_ff(rd_data_ff), .somi_oe_ff(somi_oe_ff), .simo_oe_ff(simo_oe_ff), .sclk_o_ff(sclk_o_ff),
  .sclk_oe_ff(sclk_oe_ff), .ste_n_i(ste_n_i), .ste_n_o_ff(ste_n_o_ff)
);
`default_nettype wire

// >>> test/spi_far_end.sv
/*
  Behavioural far-end slave facing the serial port in master role.
  Assumes scheme and length are set before the select line falls.
*/
`default_nettype none
module spi_far_end (
  input  wire logic        sclk,
  input  wire logic        ste_n,
  input  wire logic        simo,
  input  wire logic        pol,
  input  wire logic        pha,
  input  wire logic [3:0]  lenm1,
  input  wire logic [15:0] tx_word,
  output var  logic        somi,
  output var  logic [15:0] rx_word
);
  timeunit 1ns;
  timeprecision 100ps;
  int idx;
  initial somi = 1'b0;
  initial rx_word = 16'h0000;
  // A released line shows the inverse of its last bit, so a stale sample cannot pass.
  always @(ste_n)
  begin
    idx = lenm1;
    if (ste_n)
      somi = ~somi;
    else
      somi = tx_word[idx];
  end
  always @(sclk)
  begin
    if (!ste_n)
    begin
      if ((sclk !== pol) ^ pha)
      begin
        rx_word = {rx_word[14:0], simo};
        idx = idx - pha;
      end
      else
      begin
        idx = idx - !pha;
        if (idx >= 0)
          somi = tx_word[idx];
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/sync_serial_port_tb.sv
/*
  Self-checking bench: register bus, master transfers in all schemes, FIFO, slave select.
  Assumes the far-end model and the checker are compiled before it.
*/
`default_nettype none
`include "ssp_map.vh"
module sync_serial_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, wr_en, rd_en, rx_irq_ff, tx_irq_ff, pol, pha, tb_sclk, tb_ste_n, p_somi;
  logic        somi_i, somi_o_ff, somi_oe_ff, simo_i, simo_o_ff, simo_oe_ff, sclk_i, sclk_o_ff, sclk_oe_ff;
  logic        ste_n_i, ste_n_o_ff, ste_oe_ff, prev_sclk, prev_ste, simo_seen;
  logic [3:0]  lenm1;
  logic [15:0] addr, wr_data, rd_data_ff, p_tx, p_rx, r, tx, msk;
  logic [15:0] q[$];
  logic [31:0] seed;
  int          n_fail, tests_run, cyc, last_lead, per, frames, i, k, d, eff;
  int          dv[8] = '{1, 3, 9, 127, 2, 7, 0, 12};
  logic [15:0] regs[5] = '{`ADDR_CONFIG_CONTROL, `ADDR_OPERATION_CONTROL, `ADDR_PORT_STATUS,
                           `ADDR_BIT_RATE_DIVISOR, 16'h7043};
  assign sclk_i = sclk_oe_ff ? sclk_o_ff : tb_sclk;
  assign ste_n_i = ste_oe_ff ? ste_n_o_ff : tb_ste_n;
  assign simo_i = simo_oe_ff ? simo_o_ff : ~simo_o_ff;
  assign somi_i = somi_oe_ff ? somi_o_ff : p_somi;
  sync_serial_port sync_serial_port_inst (
    .clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data),
    .rd_data_ff(rd_data_ff), .rx_irq_ff(rx_irq_ff), .tx_irq_ff(tx_irq_ff),
    .somi_i(somi_i), .somi_o_ff(somi_o_ff), .somi_oe_ff(somi_oe_ff),
    .simo_i(simo_i), .simo_o_ff(simo_o_ff), .simo_oe_ff(simo_oe_ff),
    .sclk_i(sclk_i), .sclk_o_ff(sclk_o_ff), .sclk_oe_ff(sclk_oe_ff),
    .ste_n_i(ste_n_i), .ste_n_o_ff(ste_n_o_ff), .ste_oe_ff(ste_oe_ff)
  );
  spi_far_end spi_far_end_inst (
    .sclk(sclk_i), .ste_n(ste_n_i), .simo(simo_i), .pol(pol), .pha(pha), .lenm1(lenm1),
    .tx_word(p_tx), .somi(p_somi), .rx_word(p_rx)
  );
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    prev_sclk <= sclk_o_ff;
    prev_ste <= ste_n_o_ff;
    if (sclk_oe_ff && sclk_o_ff !== pol && prev_sclk === pol)
    begin
      per <= cyc - last_lead;
      last_lead <= cyc;
    end
    if (simo_oe_ff)
      simo_seen <= 1'b1;
    if (ste_oe_ff && ste_n_o_ff === 1'b0 && prev_ste === 1'b1)
      frames <= frames + 1;
  end
  function automatic void rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction
  task automatic end_sim();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(negedge clk);
    addr = a;
    wr_data = v;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    r = rd_data_ff;
  endtask
  task automatic wait_val(input logic [15:0] a, input logic [15:0] m, input logic [15:0] v);
    for (int j = 0; j < 3000; j++)
    begin
      rd(a);
      if ((r & m) === v)
        return;
    end
    n_fail++;
    $display("CHECK FAILED wait %h expected %h seen %h", a, v, r & m);
    end_sim();
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("CHECK FAILED run length expected %h seen %h", 16'h0000, 16'hFFFF);
    end_sim();
  end
  initial
  begin
    {rst, wr_en, rd_en, tb_sclk, tb_ste_n, pol, pha, simo_seen} = 8'h88;
    addr = 16'h0000;
    wr_data = 16'h0000;
    lenm1 = 4'h0;
    p_tx = 16'h0000;
    seed = 32'h0000000B;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    for (i = 0; i < 5; i++)
    begin
      rd(regs[i]);
      chk("reset value", 16'h0000, r);
    end
    wr(`ADDR_PRIORITY_CONTROL, 16'hA55A);
    rd(`ADDR_PRIORITY_CONTROL);
    chk("byte lane", 16'h005A, r);
    // Every scheme twice; fast rates skip the receive compare since input sampling lags two cycles.
    for (i = 0; i < 8; i++)
    begin
      rnd();
      tx = seed[15:0];
      pol = i[1];
      pha = i[0];
      lenm1 = (i > 5) ? 4'hF : {1'b0, seed[22:20]};
      rnd();
      p_tx = seed[15:0];
      d = dv[i];
      eff = (d < 3) ? 4 : d + 1;
      msk = 16'hFFFF >> (4'hF - lenm1);
      wr(`ADDR_CONFIG_CONTROL, 16'h0000);
      wr(`ADDR_BIT_RATE_DIVISOR, d[15:0]);
      wr(`ADDR_OPERATION_CONTROL, {12'h000, pha, 3'h7});
      wr(`ADDR_TX_BUFFER, tx);
      wr(`ADDR_CONFIG_CONTROL, {8'h00, 1'b1, pol, 2'h0, lenm1});
      wait_val(`ADDR_PORT_STATUS, 16'h0040, 16'h0040);
      chk("rx interrupt", 16'h0001, {15'h0000, rx_irq_ff});
      chk("far end word", tx & msk & 16'h00FF, p_rx & msk);
      if (lenm1 != 4'h0)
        chk("bit period", eff[15:0], per[15:0]);
      rd(`ADDR_RX_BUFFER);
      if (eff >= 8)
        chk("received word", p_tx & msk & 16'h00FF, r);
      rd(`ADDR_PORT_STATUS);
      chk("status after read", 16'h0000, r);
    end
    wr(`ADDR_CONFIG_CONTROL, 16'h0000);
    wr(`ADDR_OPERATION_CONTROL, 16'h0005);
    {pol, pha, lenm1} = 6'h07;
    simo_seen = 1'b0;
    wr(`ADDR_TX_BUFFER, 16'h00FF);
    wr(`ADDR_CONFIG_CONTROL, 16'h0087);
    wait_val(`ADDR_PORT_STATUS, 16'h0040, 16'h0040);
    chk("master out driven", 16'h0000, {15'h0000, simo_seen});
    rd(`ADDR_RX_EMULATION);
    chk("received word", p_tx & 16'h00FF, r);
    wr(`ADDR_TX_BUFFER, 16'h0000);
    wait_val(`ADDR_PORT_STATUS, 16'h00C0, 16'h00C0);
    wr(`ADDR_PORT_STATUS, 16'h0080);
    rd(`ADDR_PORT_STATUS);
    chk("overrun cleared", 16'h0040, r);
    rd(`ADDR_RX_BUFFER);
    wr(`ADDR_CONFIG_CONTROL, 16'h0000);
    wr(`ADDR_OPERATION_CONTROL, 16'h0026);
    for (k = 0; k < 17; k++)
    begin
      wr(`ADDR_TX_BUFFER, k[15:0]);
      if (q.size() < 16)
        q.push_back(k[15:0]);
    end
    rd(`ADDR_FIFO_TX_CONTROL);
    chk("tx level", 16'h0010, r);
    rd(`ADDR_PORT_STATUS);
    chk("tx full", 16'h0020, r);
    frames = 0;
    wr(`ADDR_CONFIG_CONTROL, 16'h0080);
    wait_val(`ADDR_FIFO_TX_CONTROL, 16'h001F, 16'h0000);
    for (k = 0; k < 200 && tx_irq_ff !== 1'b1; k++)
      @(negedge clk);
    chk("tx interrupt", 16'h0001, {15'h0000, tx_irq_ff});
    chk("frames sent", 16'(q.size()), frames[15:0]);
    wr(`ADDR_CONFIG_CONTROL, 16'h0000);
    wr(`ADDR_OPERATION_CONTROL, 16'h0002);
    wr(`ADDR_PORT_STATUS, 16'h0080);
    rd(`ADDR_RX_BUFFER);
    wr(`ADDR_TX_BUFFER, 16'h00A5);
    wr(`ADDR_CONFIG_CONTROL, 16'h0087);
    for (k = 0; k < 32; k++)
      @(negedge clk) tb_sclk = ~tb_sclk;
    rd(`ADDR_PORT_STATUS);
    chk("idle slave status", 16'h0000, r);
    chk("idle slave output", 16'h0000, {15'h0000, somi_oe_ff});
    @(negedge clk) tb_ste_n = 1'b0;
    for (k = 0; k < 10 && somi_oe_ff !== 1'b1; k++)
      @(negedge clk);
    chk("slave output", 16'h0001, {15'h0000, somi_oe_ff});
    // Slow slave clock; the released slave-in line shows the inverse of the slave's own bit.
    for (k = 0; k < 16; k++)
    begin
      repeat (6) @(negedge clk);
      if (!k[0])
        chk("slave out bit", (16'h00A5 >> (7 - k / 2)) & 16'h0001, {15'h0000, somi_o_ff});
      tb_sclk = ~tb_sclk;
    end
    wait_val(`ADDR_PORT_STATUS, 16'h0040, 16'h0040);
    rd(`ADDR_RX_BUFFER);
    chk("slave word", 16'h005A, r);
    @(negedge clk) tb_ste_n = 1'b1;
    end_sim();
  end
endmodule
`default_nettype wire
